/* inc/serial_frame_cfg.svh */
// Summary of operation
// - High is one, low is zero.
// - Line idles high before any message.
// - One low start bit opens each frame.
// - Data bits travel least significant first.
// - Stop bit high, slot ten or eleven.
// - Break is low for whole frames.
// - Sleeping receiver waits for idle string.
// - Set top data bit wakes sleeping receivers.
// - Sample at sixteen ticks, resync on start.
// - Three verification samples, two-of-three decides start.
// - One high verification sample sets noise.
// - Sample ticks 8,9,10, majority vote.
// - Disagreeing bit samples set noise flag.
// - Framing error forces artificial start qualifiers.
// - After break, require real one first.
// - Data window reads receive, writes transmit.
// - Receive transfer sets full flag on tick.
// - Transmit load only after byte sent.
// - Received ninth bit in control bit 7.
// - Transmit ninth bit from control bit 6.
// - Control bit 4 picks word length.
// - Control bit 3 picks wake method.
// - Sleep blocks flags; address wake stores byte.
/*
  Constants of the asynchronous serial frame core: register offsets, field
  positions and reset values. Assumes inclusion by bare name only.
*/
`ifndef SERIAL_FRAME_CFG_SVH
`define SERIAL_FRAME_CFG_SVH
`define OFS_DATA       4'h0
`define OFS_FRAME_CTRL 4'hE
`define OFS_CTRL2      4'h4
`define OFS_STATUS     4'h8
`define OFS_DIVIDER    4'hC
`define FC_RX_NINTH    7
`define FC_TX_NINTH    6
`define FC_LONG_WORD   4
`define FC_WAKE_ADDR   3
`define C2_TX_EN       0
`define C2_RX_EN       1
`define C2_SLEEP       2
`define ST_RX_FULL     0
`define ST_FRAME_ERR   1
`define ST_NOISE       2
`define ST_TX_EMPTY    3
`define DIV_RESET      16'h0043
`define TICKS_PER_BIT  5'h10
`define SAMPLE_A       4'h8
`define SAMPLE_B       4'h9
`define SAMPLE_C       4'hA
`define IDLE_TICKS_SHORT 8'hA0
`define IDLE_TICKS_LONG  8'hB0
`endif

/* inc/serial_frame_pkg.sv */
/*
  Types used by the device end of the serial link; the far end uses none.
  Assumes the cfg header for numeric constants.
*/
package serial_frame_pkg;
  typedef enum logic [1:0] {
    RX_IDLE   = 2'b00,
    RX_VERIFY = 2'b01,
    RX_FRAME  = 2'b10,
    RX_WAIT1  = 2'b11
  } rx_state_t;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01
  } tx_state_t;
  function automatic logic majority3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction
endpackage

/* inc/serial_link_if.sv */
/*
  The two serial wires between the device end and the far end.
  Assumes both ends run on the same mclk.
*/
`timescale 1ns/10ps
interface serial_link_if;
  logic toDevice;
  logic fromDevice;
  modport device (input toDevice, output fromDevice);
  modport remote (output toDevice, input fromDevice);
endinterface

/* design/serial_tick_gen.sv */
/*
  Programmable divider producing the oversample tick.
  Assumes a nonzero divisor; zero is treated as one.
*/
`timescale 1ns/10ps
module serial_tick_gen (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [15:0] divisor,
  output logic             tick
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        tick_next;
  always_comb begin
    tick_next  = 1'b0;
    count_next = count_reg + 16'h0001;
    if (count_reg + 16'h0001 >= divisor) begin
      count_next = 16'h0000;
      tick_next  = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 16'h0000;
      tick      <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick      <= tick_next;
    end
  end
endmodule

/* design/serial_frame_device.sv */
/*
  Device end: data window, frame control, receiver with start verification,
  majority voting, wake-up, and transmitter. Registers over Avalon-MM.
  Assumes serial input synchronous to mclk and a link partner on the interface.
*/
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps
`include "serial_frame_cfg.svh"
module serial_frame_device (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  serial_link_if.device    link
);
  logic        tick;
  logic [15:0] div_reg, div_next;
  logic [7:0]  fc_reg, fc_next;
  logic [2:0]  c2_reg, c2_next;
  logic        full_reg, full_next, fe_reg, fe_next, nf_reg, nf_next, te_reg, te_next;
  logic [7:0]  rdr_reg, rdr_next, tdr_reg, tdr_next;
  logic [31:0] readdata_next;
  logic        ack_reg;
  serial_frame_pkg::rx_state_t rxState_reg, rxState_next;
  logic [3:0]  rxTick_reg, rxTick_next;
  logic [3:0]  rxBit_reg, rxBit_next;
  logic [8:0]  rxShift_reg, rxShift_next;
  logic [2:0]  smp_reg, smp_next;
  logic        vnoise_reg, vnoise_next;
  logic [7:0]  ones_reg, ones_next;
  logic        forceStart_reg, forceStart_next;
  serial_frame_pkg::tx_state_t txState_reg, txState_next;
  logic [3:0]  txTick_reg, txTick_next;
  logic [3:0]  txBit_reg, txBit_next;
  logic [10:0] txShift_reg, txShift_next;
  logic        txOut_reg, txOut_next;
  logic        rdin, bitVal, bitNoise, longWord, rdAccess, wrAccess;
  logic [3:0]  lastBit;

  serial_tick_gen tickGen (
    .mclk    (mclk),
    .reset_n (reset_n),
    .divisor (div_reg),
    .tick    (tick)
  );

  assign rdin        = link.toDevice;
  assign link.fromDevice = txOut_reg;
  assign longWord    = fc_reg[`FC_LONG_WORD];
  assign lastBit     = longWord ? 4'hA : 4'h9;
  assign bitVal      = serial_frame_pkg::majority3(smp_reg[0], smp_reg[1], rdin);
  assign bitNoise    = !((smp_reg[0] == smp_reg[1]) && (smp_reg[1] == rdin));
  assign waitrequest = (read | write) & ~ack_reg;
  assign rdAccess    = read & ~ack_reg;
  assign wrAccess    = write & ~ack_reg;

  always_comb begin
    div_next = div_reg;
    fc_next  = fc_reg;
    c2_next  = c2_reg;
    tdr_next = tdr_reg;
    te_next  = te_reg;
    readdata_next = readdata;
    full_next = full_reg;
    fe_next   = fe_reg;
    nf_next   = nf_reg;
    rdr_next  = rdr_reg;
    rxState_next = rxState_reg;
    rxTick_next  = rxTick_reg;
    rxBit_next   = rxBit_reg;
    rxShift_next = rxShift_reg;
    smp_next     = smp_reg;
    vnoise_next  = vnoise_reg;
    ones_next    = ones_reg;
    forceStart_next = forceStart_reg;
    txState_next = txState_reg;
    txTick_next  = txTick_reg;
    txBit_next   = txBit_reg;
    txShift_next = txShift_reg;
    txOut_next   = txOut_reg;
    if (rdAccess) begin
      case (address)
        `OFS_DATA: begin
          readdata_next = {24'h000000, rdr_reg};
          full_next     = 1'b0;
        end
        `OFS_FRAME_CTRL: readdata_next = {24'h000000, fc_reg};
        `OFS_CTRL2:      readdata_next = {29'h00000000, c2_reg};
        `OFS_STATUS:     readdata_next = {28'h0000000, te_reg, nf_reg, fe_reg, full_reg};
        `OFS_DIVIDER:    readdata_next = {16'h0000, div_reg};
        default:         readdata_next = 32'h00000000;
      endcase
    end
    if (wrAccess) begin
      case (address)
        `OFS_DATA: begin
          tdr_next = writedata[7:0];
          te_next  = 1'b0;
        end
        `OFS_FRAME_CTRL: fc_next = {fc_reg[7], writedata[6:0] & 7'h58};
        `OFS_CTRL2:      c2_next = writedata[2:0];
        `OFS_STATUS: begin
          fe_next = fe_reg & ~writedata[`ST_FRAME_ERR];
          nf_next = nf_reg & ~writedata[`ST_NOISE];
        end
        `OFS_DIVIDER:    div_next = writedata[15:0];
        default: ;
      endcase
    end
    // Transmitter: one bit per sixteen ticks
    if (tick) begin
      case (txState_reg)
        serial_frame_pkg::TX_IDLE: begin
          txOut_next = 1'b1;
          if (c2_next[`C2_TX_EN] && !te_next) begin
            txShift_next = longWord ? {1'b1, fc_reg[`FC_TX_NINTH], tdr_next, 1'b0}
                                    : {2'b11, tdr_next, 1'b0};
            te_next      = 1'b1;
            txBit_next   = 4'h0;
            txTick_next  = 4'h0;
            txState_next = serial_frame_pkg::TX_SHIFT;
          end
        end
        serial_frame_pkg::TX_SHIFT: begin
          txTick_next = txTick_reg + 4'h1;
          if (txTick_reg == 4'h0) begin
            txOut_next   = txShift_reg[0];
            txShift_next = {1'b1, txShift_reg[10:1]};
            txBit_next   = txBit_reg + 4'h1;
          end
          if (txTick_reg == 4'hF && txBit_reg == lastBit + 4'h1)
            txState_next = serial_frame_pkg::TX_IDLE;
        end
        default: txState_next = serial_frame_pkg::TX_IDLE;
      endcase
    end
    // Receiver
    if (tick && c2_reg[`C2_RX_EN]) begin
      rxTick_next = rxTick_reg + 4'h1;
      // Idle string counted in ticks: ten or eleven whole bit times of high line
      if (rdin) ones_next = (ones_reg == 8'hFF) ? ones_reg : ones_reg + 8'h01;
      else      ones_next = 8'h00;
      if (!fc_reg[`FC_WAKE_ADDR] && c2_reg[`C2_SLEEP] && rxState_reg == serial_frame_pkg::RX_IDLE &&
          ones_reg >= (longWord ? `IDLE_TICKS_LONG : `IDLE_TICKS_SHORT))
        c2_next[`C2_SLEEP] = 1'b0;
      case (rxState_reg)
        serial_frame_pkg::RX_IDLE: begin
          // Detection tick is tick 1 of the bit; an artificial start waits for that slot
          if (forceStart_reg ? (rxTick_reg == 4'h1) : !rdin) begin
            rxState_next = serial_frame_pkg::RX_VERIFY;
            rxTick_next  = 4'h2;
            smp_next     = forceStart_reg ? 3'b111 : 3'b000;
            forceStart_next = 1'b0;
          end
        end
        serial_frame_pkg::RX_VERIFY: begin
          smp_next = {smp_reg[1:0], rdin};
          if (rxTick_reg == 4'h4) begin
            if (serial_frame_pkg::majority3(smp_reg[0], smp_reg[1], rdin)) begin
              rxState_next = serial_frame_pkg::RX_IDLE;
            end else begin
              vnoise_next  = smp_reg[0] | smp_reg[1] | rdin;
              rxState_next = serial_frame_pkg::RX_FRAME;
              rxBit_next   = 4'h0;
            end
          end
        end
        serial_frame_pkg::RX_FRAME: begin
          if (rxTick_reg == `SAMPLE_A || rxTick_reg == `SAMPLE_B)
            smp_next = {smp_reg[1:0], rdin};
          if (rxTick_reg == `SAMPLE_C) begin
            vnoise_next  = vnoise_reg | bitNoise;
            rxBit_next   = rxBit_reg + 4'h1;
            if (rxBit_reg != 4'h0 && rxBit_reg != lastBit)
              rxShift_next = longWord ? {bitVal, rxShift_reg[8:1]}
                                      : {1'b0, bitVal, rxShift_reg[7:1]};
            if (rxBit_reg == lastBit) begin
              rxState_next = serial_frame_pkg::RX_IDLE;
              if (!(c2_reg[`C2_SLEEP] && !(fc_reg[`FC_WAKE_ADDR] &&
                    (longWord ? rxShift_reg[8] : rxShift_reg[7])))) begin
                if (c2_reg[`C2_SLEEP]) c2_next[`C2_SLEEP] = 1'b0;
                rdr_next  = rxShift_reg[7:0];
                fc_next[`FC_RX_NINTH] = rxShift_reg[8];
                full_next = 1'b1;
                fe_next   = fe_reg | !bitVal;
                nf_next   = nf_reg | vnoise_reg | bitNoise;
              end
              if (!bitVal) begin
                if (rxShift_reg[7:0] == 8'h00 && !rxShift_reg[8]) begin
                  rxState_next = serial_frame_pkg::RX_WAIT1;
                end else begin
                  forceStart_next = 1'b1;
                  rxShift_next[8] = 1'b1;
                end
              end
              vnoise_next = 1'b0;
            end
          end
          if (rxTick_reg == 4'hF) rxTick_next = 4'h0;
        end
        serial_frame_pkg::RX_WAIT1: if (rdin) rxState_next = serial_frame_pkg::RX_IDLE;
        default: rxState_next = serial_frame_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= `DIV_RESET;
      c2_reg  <= 3'h0;
      tdr_reg <= 8'h00;
      te_reg  <= 1'b1;
      readdata <= 32'h00000000;
      ack_reg <= 1'b0;
      full_reg <= 1'b0;
      fe_reg  <= 1'b0;
      nf_reg  <= 1'b0;
      rdr_reg <= 8'h00;
      rxState_reg <= serial_frame_pkg::RX_IDLE;
      rxTick_reg  <= 4'h0;
      rxBit_reg   <= 4'h0;
      rxShift_reg <= 9'h000;
      smp_reg     <= 3'h0;
      vnoise_reg  <= 1'b0;
      ones_reg    <= 8'h00;
      forceStart_reg <= 1'b0;
      txState_reg <= serial_frame_pkg::TX_IDLE;
      txTick_reg  <= 4'h0;
      txBit_reg   <= 4'h0;
      txShift_reg <= 11'h7FF;
      txOut_reg   <= 1'b1;
    end else begin
      div_reg <= div_next;
      c2_reg  <= c2_next;
      tdr_reg <= tdr_next;
      te_reg  <= te_next;
      readdata <= readdata_next;
      ack_reg <= (read | write) & ~ack_reg;
      full_reg <= full_next;
      fe_reg  <= fe_next;
      nf_reg  <= nf_next;
      rdr_reg <= rdr_next;
      rxState_reg <= rxState_next;
      rxTick_reg  <= rxTick_next;
      rxBit_reg   <= rxBit_next;
      rxShift_reg <= rxShift_next;
      smp_reg     <= smp_next;
      vnoise_reg  <= vnoise_next;
      ones_reg    <= ones_next;
      forceStart_reg <= forceStart_next;
      txState_reg <= txState_next;
      txTick_reg  <= txTick_next;
      txBit_reg   <= txBit_next;
      txShift_reg <= txShift_next;
      txOut_reg   <= txOut_next;
    end
  end

  // Frame control: format bits survive reset, so no reset branch
  always_ff @(posedge mclk) begin
    fc_reg <= fc_next;
  end
endmodule

/* design/serial_frame_remote.sv */
/*
  Far end: a plain asynchronous transmitter/receiver at the same bit rate.
  Assumes the same mclk and a fixed divider matching the device.
*/
`timescale 1ns/10ps
`include "serial_frame_cfg.svh"
module serial_frame_remote (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [15:0] divisor,
  input  wire logic       longWord,
  input  wire logic       sendValid,
  input  wire logic [8:0] sendData,
  output logic            sendReady,
  output logic            recvValid,
  output logic [8:0]      recvData,
  serial_link_if.remote   link
);
  logic        tick;
  logic [3:0]  tt_reg, tt_next, tb_reg, tb_next, rt_reg, rt_next, rb_reg, rb_next;
  logic [10:0] ts_reg, ts_next;
  logic        busy_reg, busy_next, out_reg, out_next;
  logic        rbusy_reg, rbusy_next, rv_next;
  logic [8:0]  rs_reg, rs_next, rd_next;
  logic [3:0]  last;

  serial_tick_gen tickGen (
    .mclk    (mclk),
    .reset_n (reset_n),
    .divisor (divisor),
    .tick    (tick)
  );

  assign last = longWord ? 4'hA : 4'h9;
  assign link.toDevice = out_reg;
  assign sendReady = ~busy_reg;

  always_comb begin
    tt_next = tt_reg; tb_next = tb_reg; ts_next = ts_reg;
    busy_next = busy_reg; out_next = out_reg;
    rt_next = rt_reg; rb_next = rb_reg; rs_next = rs_reg;
    rbusy_next = rbusy_reg; rv_next = 1'b0; rd_next = recvData;
    if (sendValid && !busy_reg) begin
      ts_next   = longWord ? {1'b1, sendData, 1'b0} : {2'b11, sendData[7:0], 1'b0};
      busy_next = 1'b1;
      tt_next   = 4'h0;
      tb_next   = 4'h0;
    end else if (tick && busy_reg) begin
      tt_next = tt_reg + 4'h1;
      if (tt_reg == 4'h0) begin
        out_next = ts_reg[0];
        ts_next  = {1'b1, ts_reg[10:1]};
        tb_next  = tb_reg + 4'h1;
      end
      if (tt_reg == 4'hF && tb_reg == last + 4'h1) busy_next = 1'b0;
    end
    if (tick) begin
      if (!rbusy_reg) begin
        if (!link.fromDevice) begin
          rbusy_next = 1'b1;
          rt_next = 4'h1;
          rb_next = 4'h0;
        end
      end else begin
        rt_next = rt_reg + 4'h1;
        if (rt_reg == `SAMPLE_B) begin
          rb_next = rb_reg + 4'h1;
          if (rb_reg != 4'h0) rs_next = {link.fromDevice, rs_reg[8:1]};
          if (rb_reg == last) begin
            rbusy_next = 1'b0;
            rv_next = 1'b1;
            rd_next = longWord ? rs_reg : {1'b0, rs_reg[8:1]};
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tt_reg <= 4'h0; tb_reg <= 4'h0; ts_reg <= 11'h7FF;
      busy_reg <= 1'b0; out_reg <= 1'b1;
      rt_reg <= 4'h0; rb_reg <= 4'h0; rs_reg <= 9'h000;
      rbusy_reg <= 1'b0; recvValid <= 1'b0; recvData <= 9'h000;
    end else begin
      tt_reg <= tt_next; tb_reg <= tb_next; ts_reg <= ts_next;
      busy_reg <= busy_next; out_reg <= out_next;
      rt_reg <= rt_next; rb_reg <= rb_next; rs_reg <= rs_next;
      rbusy_reg <= rbusy_next; recvValid <= rv_next; recvData <= rd_next;
    end
  end
endmodule

/* verification/serial_frame_assertions.sv */
/*
  Checker on the two serial wires between the device end and the far end.
  Assumes one mclk domain and BIT_CYCLES mclk cycles per serial bit.
*/
`timescale 1ns/10ps
module serial_frame_assertions #(
  parameter int BIT_CYCLES = 32
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic toDevice,
  input wire logic fromDevice
);
  localparam int LOW_MAX = 10 * BIT_CYCLES;
  logic [15:0] lowTx_reg, lowTx_next, highTx_reg, highTx_next;
  logic [15:0] lowRx_reg, lowRx_next, highRx_reg, highRx_next;
  // High runs saturate so a long idle cannot wrap into a short stop gap
  always_comb begin
    lowTx_next = fromDevice ? 16'h0000 : lowTx_reg + 16'h0001;
    lowRx_next = toDevice ? 16'h0000 : lowRx_reg + 16'h0001;
    highTx_next = !fromDevice ? 16'h0000 : highTx_reg + {15'h0000, ~&highTx_reg};
    highRx_next = !toDevice ? 16'h0000 : highRx_reg + {15'h0000, ~&highRx_reg};
  end
  // Reset leaves the line idle, which counts as a full stop gap
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lowTx_reg <= 16'h0000;
      lowRx_reg <= 16'h0000;
      highTx_reg <= 16'(BIT_CYCLES);
      highRx_reg <= 16'(BIT_CYCLES);
    end else begin
      lowTx_reg <= lowTx_next;
      lowRx_reg <= lowRx_next;
      highTx_reg <= highTx_next;
      highRx_reg <= highRx_next;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence startTx;
    !fromDevice [*8];
  endsequence
  sequence startRx;
    !toDevice [*8];
  endsequence
  chk_idle_after_reset: assert property ($rose(reset_n) |-> toDevice && fromDevice)
    else $error("line not idle high after reset");
  chk_tx_start_low: assert property ($fell(fromDevice) |-> startTx)
    else $error("device start bit too short");
  chk_rx_start_low: assert property ($fell(toDevice) |-> startRx)
    else $error("remote start bit too short");
  chk_tx_bit_grid: assert property ($rose(fromDevice) |-> lowTx_reg % BIT_CYCLES == 0)
    else $error("device low run off the bit grid");
  chk_rx_bit_grid: assert property ($rose(toDevice) |-> lowRx_reg % BIT_CYCLES == 0)
    else $error("remote low run off the bit grid");
  chk_tx_stop_gap: assert property ($fell(fromDevice) |-> highTx_reg >= BIT_CYCLES)
    else $error("device stop bit missing");
  chk_rx_stop_gap: assert property ($fell(toDevice) |-> highRx_reg >= BIT_CYCLES)
    else $error("remote stop bit missing");
  chk_tx_low_limit: assert property (lowTx_reg <= LOW_MAX)
    else $error("device line low past one frame");
  chk_rx_low_limit: assert property (lowRx_reg <= LOW_MAX)
    else $error("remote line low past one frame");
endmodule

/* verification/testbench.sv */
/*
  Bench joining device end and far end over the link, plus a second device
  end fed by a bench driver that mangles frames. Assumes the cfg header map.
*/
`timescale 1ns/10ps
`include "serial_frame_cfg.svh"
module testbench;
  localparam int BIT = 32;
  logic        mclk, reset_n, read, write, sel, sendValid, longWord;
  logic        waitrequest, waitrequest2, wq, sendReady, recvValid;
  logic [3:0]  address;
  logic [7:0]  b;
  logic [8:0]  sendData, recvData;
  logic [31:0] writedata, readdata, readdata2, rdq, e, m;
  logic [31:0] expRd[$], mskRd[$];
  logic [8:0]  expRx[$];
  int          fail_count, n_tests, cycles;
  serial_link_if link();
  serial_link_if link2();
  assign rdq = sel ? readdata2 : readdata;
  assign wq = sel ? waitrequest2 : waitrequest;
  serial_frame_device serial_frame_device_inst (.mclk(mclk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .link(link.device));
  // Shares the bus inputs, so every write lands in both device ends
  serial_frame_device serial_frame_device_inst2 (.mclk(mclk), .reset_n(reset_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata2), .waitrequest(waitrequest2),
    .link(link2.device));
  serial_frame_remote serial_frame_remote_inst (.mclk(mclk), .reset_n(reset_n), .divisor(16'h0002),
    .longWord(longWord), .sendValid(sendValid), .sendData(sendData), .sendReady(sendReady),
    .recvValid(recvValid), .recvData(recvData), .link(link.remote));
  serial_frame_assertions #(.BIT_CYCLES(BIT)) serial_frame_assertions_inst (.mclk(mclk),
    .reset_n(reset_n), .toDevice(link.toDevice), .fromDevice(link.fromDevice));
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] ex,
                     input logic [31:0] mk, output logic [31:0] q);
    @(posedge mclk);
    if (!wr) begin
      expRd.push_back(ex & mk);
      mskRd.push_back(mk);
    end
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    // Waitrequest and read data are taken at the same rising edge
    do @(posedge mclk); while (wq !== 1'h0);
    q = rdq;
    read <= 1'h0;
    write <= 1'h0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, 32'h0, 32'h0, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic [31:0] mk);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, ex, mk, q);
  endtask
  task automatic poll(input int bitIdx);
    logic [31:0] q;
    do bus(1'h0, `OFS_STATUS, 32'h0, 32'h0, 32'h0, q);
    while (q[bitIdx] !== 1'h1);
  endtask
  task automatic dsend(input logic [8:0] d);
    poll(`ST_TX_EMPTY);
    expRx.push_back(longWord ? d : {1'h0, d[7:0]});
    wr(`OFS_DATA, {24'h0, d[7:0]});
  endtask
  // Only the cycle ceiling ends a wait that never completes
  task automatic drain();
    while (expRx.size() != 0) @(negedge mclk);
  endtask
  task automatic rsend(input logic [8:0] d);
    @(posedge mclk);
    sendValid <= 1'h1;
    sendData <= d;
    do @(posedge mclk); while (sendReady !== 1'h1);
    sendValid <= 1'h0;
  endtask
  // Samples mid-bit so the check does not race the launching edge
  task automatic wireCheck(input logic [7:0] d);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    while (link.fromDevice !== 1'h0) @(negedge mclk);
    repeat (BIT / 2) @(negedge mclk);
    for (int i = 0; i < 10; i++) begin
      chk({31'h0, link.fromDevice}, {31'h0, f[i]});
      repeat (BIT) @(negedge mclk);
    end
  endtask
  // Glitch g flips one oversample tick in the middle of bit g
  task automatic raw(input logic [9:0] f, input int g);
    for (int i = 0; i < 10; i++)
      for (int c = 0; c < BIT; c++) begin
        @(posedge mclk);
        link2.toDevice <= f[i] ^ (i == g && c >= 16 && c < 18);
      end
  endtask
  always @(negedge mclk) begin
    if (read === 1'h1 && wq === 1'h0 && mskRd.size() > 0) begin
      e = expRd.pop_front();
      m = mskRd.pop_front();
      if (m != 32'h0)
        chk(rdq & m, e);
    end
    if (recvValid === 1'h1)
      chk({23'h0, recvData & (longWord ? 9'h1FF : 9'h0FF)}, {23'h0, expRx.pop_front()});
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    {reset_n, read, write, sel, sendValid, longWord} = 6'h00;
    {address, writedata, sendData} = 45'h0;
    link2.toDevice = 1'h1;
    {fail_count, n_tests, cycles} = 96'h0;
    b = 8'($urandom(62));
    repeat (4) @(posedge mclk);
    reset_n <= 1'h1;
    rd(`OFS_DIVIDER, 32'h43, 32'hFFFF);
    rd(`OFS_STATUS, 32'h8, 32'hF);
    wr(4'h2, 32'hFF);
    rd(4'h2, 32'h0, 32'hFFFFFFFF);
    wr(`OFS_DIVIDER, 32'h2);
    wr(`OFS_CTRL2, 32'h3);
    wr(`OFS_FRAME_CTRL, 32'h0);
    fork
      wireCheck(8'hA6);
    join_none
    dsend(9'h0A6);
    for (int k = 0; k < 3; k++)
      dsend({1'h0, 8'($urandom)});
    drain();
    for (int k = 0; k < 3; k++) begin
      b = (k == 0) ? 8'h01 : (k == 1) ? 8'h80 : 8'($urandom);
      rsend({1'h0, b});
      poll(`ST_RX_FULL);
      rd(`OFS_DATA, {24'h0, b}, 32'hFF);
      rd(`OFS_STATUS, 32'h0, 32'h1);
    end
    longWord <= 1'h1;
    for (int n9 = 0; n9 < 2; n9++) begin
      wr(`OFS_FRAME_CTRL, n9 ? 32'h50 : 32'h10);
      dsend({n9[0], 8'h5C});
      drain();
      rsend({n9[0], 8'h3B});
      poll(`ST_RX_FULL);
      rd(`OFS_FRAME_CTRL, n9 ? 32'hD0 : 32'h10, 32'hD8);
      rd(`OFS_DATA, 32'h3B, 32'hFF);
    end
    longWord <= 1'h0;
    wr(`OFS_FRAME_CTRL, 32'h08);
    wr(`OFS_CTRL2, 32'h7);
    rsend(9'h012);
    rsend(9'h093);
    poll(`ST_RX_FULL);
    rd(`OFS_STATUS, 32'h1, 32'h7);
    rd(`OFS_DATA, 32'h93, 32'hFF);
    rd(`OFS_CTRL2, 32'h3, 32'h7);
    wr(`OFS_CTRL2, 32'h3);
    wr(`OFS_FRAME_CTRL, 32'h0);
    // Sleep set inside a frame, so three back-to-back frames pass unseen
    rsend(9'h012);
    repeat (BIT / 2) @(posedge mclk);
    wr(`OFS_CTRL2, 32'h7);
    rsend(9'h034);
    rsend(9'h056);
    repeat (22 * BIT) @(posedge mclk);
    rd(`OFS_STATUS, 32'h0, 32'h1);
    rsend(9'h078);
    poll(`ST_RX_FULL);
    rd(`OFS_DATA, 32'h78, 32'hFF);
    rd(`OFS_CTRL2, 32'h3, 32'h7);
    sel = 1'h1;
    raw({1'h1, 8'hC3, 1'h0}, 3);
    poll(`ST_RX_FULL);
    rd(`OFS_STATUS, 32'h5, 32'h7);
    rd(`OFS_DATA, 32'hC3, 32'hFF);
    wr(`OFS_STATUS, 32'h4);
    raw({1'h0, 8'h5A, 1'h0}, -1);
    raw({1'h1, 8'h3C, 1'h0}, -1);
    rd(`OFS_STATUS, 32'h3, 32'h7);
    rd(`OFS_DATA, 32'h3C, 32'hFF);
    wr(`OFS_STATUS, 32'h2);
    raw(10'h000, -1);
    raw(10'h3FF, -1);
    raw({1'h1, 8'h81, 1'h0}, -1);
    rd(`OFS_DATA, 32'h81, 32'hFF);
    tally_and_finish();
  end
endmodule
